// ==== rtl/output_margin_control.sv ====
`default_nettype none
module output_margin_control #(
  parameter logic [7:0] NOMINAL_RESET = 8'h00,
  parameter logic [7:0] CEILING_RESET = 8'hff
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic link_clk_in,
  input wire logic link_rst_n_in,
  input wire logic txn_valid_in,
  input wire logic txn_write_in,
  input wire logic txn_word_in,
  input wire logic [7:0] txn_code_in,
  input wire logic [15:0] txn_data_in,
  output logic txn_ready_out,
  output logic rd_valid_out,
  output logic [15:0] rd_data_out,
  input wire logic channel_a_enable_pin_in,
  input wire logic channel_b_enable_pin_in,
  output logic host_alert_line_out,
  output logic host_alert_line_oe_out,
  output logic [1:0] run_out,
  output logic [7:0] target_a_out,
  output logic [7:0] target_b_out,
  output logic [1:0] fault_detect_en_out
);
  // a reset nominal above the reset ceiling would break the ceiling guard from the first cycle
  if (NOMINAL_RESET > CEILING_RESET) $error("nominal reset above ceiling reset");
  // ----------------------------------------
  // link domain: capture and request toggle
  // ----------------------------------------
  logic req_q;
  logic ack_seen_q;
  logic h_write_q;
  logic h_word_q;
  logic [7:0] h_code_q;
  logic [15:0] h_data_q;
  logic [15:0] rd_data_q;
  logic rd_valid_q;
  logic ack_link;
  logic [15:0] rdata_core_q;
  wire link_busy = req_q != ack_link;
  wire link_take = txn_valid_in && !link_busy;
  wire ack_new = ack_link != ack_seen_q;

  // holding registers stay still until the core echoes the toggle
  always_ff @(posedge link_clk_in) begin
    if (!link_rst_n_in) begin
      req_q <= 1'b0;
      ack_seen_q <= 1'b0;
      h_write_q <= 1'b0;
      h_word_q <= 1'b0;
      h_code_q <= 8'h00;
      h_data_q <= 16'h0000;
      rd_data_q <= 16'h0000;
      rd_valid_q <= 1'b0;
    end else begin
      ack_seen_q <= ack_link;
      rd_valid_q <= ack_new && !h_write_q;
      if (ack_new) rd_data_q <= rdata_core_q;
      if (link_take) begin
        req_q <= !req_q;
        h_write_q <= txn_write_in;
        h_word_q <= txn_word_in;
        h_code_q <= txn_code_in;
        h_data_q <= txn_data_in;
      end
    end
  end

  assign txn_ready_out = !link_busy;
  assign rd_valid_out = rd_valid_q;
  assign rd_data_out = rd_data_q;

  // ----------------------------------------
  // crossings
  // ----------------------------------------
  logic req_core;
  logic ack_q;
  logic [1:0] pin_s;
  bit_sync2 #(.WIDTH(1)) u_req_sync (.clk_in(clk_in), .rst_n_in(rst_n_in), .async_in(req_q), .sync_out(req_core));
  bit_sync2 #(.WIDTH(1)) u_ack_sync (.clk_in(link_clk_in), .rst_n_in(link_rst_n_in), .async_in(ack_q),
    .sync_out(ack_link));
  bit_sync2 #(.WIDTH(2)) u_pin_sync (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .async_in({channel_b_enable_pin_in, channel_a_enable_pin_in}), .sync_out(pin_s));

  // ----------------------------------------
  // core state
  // ----------------------------------------
  logic [7:0] page_q;
  logic [7:0] phase_q;
  logic [7:0] comms_q;
  logic [7:0] ctrl_q [2];
  logic [7:0] src_q [2];
  logic [7:0] nom_q [2];
  logic [7:0] ceil_q [2];
  logic [7:0] low_q [2];
  logic [7:0] high_q [2];
  logic [7:0] slew_q [2];
  logic [7:0] vflags_q [2];
  logic [15:0] ofs_q [2];
  logic [1:0] run_q;

  function automatic logic is_byte_code(input logic [7:0] c);
    return c == margin_ctrl_pkg::CODE_PAGE || c == margin_ctrl_pkg::CODE_CONTROL ||
      c == margin_ctrl_pkg::CODE_ENABLE_SRC || c == margin_ctrl_pkg::CODE_PHASE ||
      c == margin_ctrl_pkg::CODE_SUMMARY || c == margin_ctrl_pkg::CODE_VFLAGS ||
      c == margin_ctrl_pkg::CODE_COMMS;
  endfunction

  function automatic logic is_word_code(input logic [7:0] c);
    return c == margin_ctrl_pkg::CODE_NOMINAL || c == margin_ctrl_pkg::CODE_CEILING ||
      c == margin_ctrl_pkg::CODE_HIGH_TRIM || c == margin_ctrl_pkg::CODE_LOW_TRIM ||
      c == margin_ctrl_pkg::CODE_SLEW || c == margin_ctrl_pkg::CODE_OFFSET;
  endfunction

  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    return v >= lo && v <= hi;
  endfunction

  // ----------------------------------------
  // transaction decode and checks
  // ----------------------------------------
  wire txn_new = req_core != ack_q;
  wire sel_a = page_q == margin_ctrl_pkg::PAGE_A || page_q == margin_ctrl_pkg::PAGE_BOTH;
  wire sel_b = page_q == margin_ctrl_pkg::PAGE_B || page_q == margin_ctrl_pkg::PAGE_BOTH;
  wire rd_ch = sel_b && !sel_a;
  wire [1:0] sel_mask = {sel_b, sel_a};
  wire code_known = is_byte_code(h_code_q) || is_word_code(h_code_q);
  wire size_ok = h_word_q == is_word_code(h_code_q);
  wire [3:0] trim_wr = h_data_q[margin_ctrl_pkg::TRIM_HI:margin_ctrl_pkg::TRIM_LO];
  wire trim_ok = trim_wr == margin_ctrl_pkg::TRIM_OFF || trim_wr == margin_ctrl_pkg::TRIM_LOW_IGN ||
    trim_wr == margin_ctrl_pkg::TRIM_LOW_ACT || trim_wr == margin_ctrl_pkg::TRIM_HIGH_IGN ||
    trim_wr == margin_ctrl_pkg::TRIM_HIGH_ACT;
  wire ofs_total_ok = !h_data_q[0] && (in_range(h_data_q, margin_ctrl_pkg::OFS_POS_MIN,
    margin_ctrl_pkg::OFS_POS_MAX) || in_range(h_data_q, margin_ctrl_pkg::OFS_NEG_MIN,
    margin_ctrl_pkg::OFS_NEG_MAX));
  wire ofs_phase_ok = in_range(h_data_q, margin_ctrl_pkg::OFS_POS_MIN, margin_ctrl_pkg::OFS_PH_POS_MAX) ||
    in_range(h_data_q, margin_ctrl_pkg::OFS_PH_NEG_MIN, margin_ctrl_pkg::OFS_PH_NEG_MAX);
  wire ofs_ok = (phase_q == margin_ctrl_pkg::PHASE_TOTAL) ? ofs_total_ok : ofs_phase_ok;
  wire page_ok = h_data_q[7:0] == margin_ctrl_pkg::PAGE_A || h_data_q[7:0] == margin_ctrl_pkg::PAGE_B ||
    h_data_q[7:0] == margin_ctrl_pkg::PAGE_BOTH;
  wire word_hi_ok = h_data_q[15:8] == 8'h00;
  // nominal above ceiling, or ceiling below nominal, is refused on every selected channel
  wire nom_ok = word_hi_ok && !(sel_a && h_data_q[7:0] > ceil_q[0]) &&
    !(sel_b && h_data_q[7:0] > ceil_q[1]);
  wire ceil_ok = word_hi_ok && !(sel_a && h_data_q[7:0] < nom_q[0]) &&
    !(sel_b && h_data_q[7:0] < nom_q[1]);
  logic data_ok;
  always_comb begin
    unique case (h_code_q)
      margin_ctrl_pkg::CODE_PAGE: data_ok = page_ok;
      margin_ctrl_pkg::CODE_CONTROL: data_ok = trim_ok;
      margin_ctrl_pkg::CODE_OFFSET: data_ok = ofs_ok;
      margin_ctrl_pkg::CODE_NOMINAL: data_ok = nom_ok;
      margin_ctrl_pkg::CODE_CEILING: data_ok = ceil_ok;
      margin_ctrl_pkg::CODE_SUMMARY: data_ok = 1'b0;
      margin_ctrl_pkg::CODE_HIGH_TRIM, margin_ctrl_pkg::CODE_LOW_TRIM,
      margin_ctrl_pkg::CODE_SLEW: data_ok = word_hi_ok;
      default: data_ok = 1'b1;
    endcase
  end
  wire txn_good = code_known && size_ok && (!h_write_q || data_ok);
  wire wr_ok = txn_new && h_write_q && txn_good;
  wire bad_cmd = txn_new && !code_known;
  wire bad_data = txn_new && code_known && !txn_good;
  wire wr_ctrl = wr_ok && h_code_q == margin_ctrl_pkg::CODE_CONTROL;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  wire [7:0] summary = {2'b00, |vflags_q[rd_ch], 3'b000, |comms_q, 1'b0};
  logic [15:0] rd_mux;
  always_comb begin
    unique case (h_code_q)
      margin_ctrl_pkg::CODE_PAGE: rd_mux = {8'h00, page_q};
      margin_ctrl_pkg::CODE_CONTROL: rd_mux = {8'h00, ctrl_q[rd_ch]};
      margin_ctrl_pkg::CODE_ENABLE_SRC: rd_mux = {8'h00, src_q[rd_ch]};
      margin_ctrl_pkg::CODE_PHASE: rd_mux = {8'h00, phase_q};
      margin_ctrl_pkg::CODE_NOMINAL: rd_mux = {8'h00, nom_q[rd_ch]};
      margin_ctrl_pkg::CODE_CEILING: rd_mux = {8'h00, ceil_q[rd_ch]};
      margin_ctrl_pkg::CODE_HIGH_TRIM: rd_mux = {8'h00, high_q[rd_ch]};
      margin_ctrl_pkg::CODE_LOW_TRIM: rd_mux = {8'h00, low_q[rd_ch]};
      margin_ctrl_pkg::CODE_SLEW: rd_mux = {8'h00, slew_q[rd_ch]};
      margin_ctrl_pkg::CODE_OFFSET: rd_mux = ofs_q[rd_ch];
      margin_ctrl_pkg::CODE_SUMMARY: rd_mux = {8'h00, summary};
      margin_ctrl_pkg::CODE_VFLAGS: rd_mux = {8'h00, vflags_q[rd_ch]};
      margin_ctrl_pkg::CODE_COMMS: rd_mux = {8'h00, comms_q};
      default: rd_mux = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // per-channel target selection
  // ----------------------------------------
  logic [3:0] trim_eff [2];
  logic [7:0] goal [2];
  logic [7:0] level [2];
  logic [1:0] warn_set;
  logic [1:0] fault_en;
  logic [1:0] on_d;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    wire respect = src_q[c][margin_ctrl_pkg::SRC_CMD_BIT];
    wire pin_on = pin_s[c] == src_q[c][margin_ctrl_pkg::SRC_POL_BIT];
    // trim is dormant unless the channel respects the command
    assign trim_eff[c] = respect ? ctrl_q[c][margin_ctrl_pkg::TRIM_HI:margin_ctrl_pkg::TRIM_LO]
      : margin_ctrl_pkg::TRIM_OFF;
    assign goal[c] = (trim_eff[c][3:2] == margin_ctrl_pkg::SEL_LOW) ? low_q[c] :
      (trim_eff[c][3:2] == margin_ctrl_pkg::SEL_HIGH) ? high_q[c] : nom_q[c];
    assign fault_en[c] = !(trim_eff[c] != margin_ctrl_pkg::TRIM_OFF &&
      trim_eff[c][1:0] == margin_ctrl_pkg::FAULT_IGNORE);
    assign warn_set[c] = trim_eff[c] != margin_ctrl_pkg::TRIM_OFF &&
      trim_eff[c][1:0] == margin_ctrl_pkg::FAULT_ACT && goal[c] > nom_q[c];
    assign on_d[c] = !src_q[c][margin_ctrl_pkg::SRC_PU_BIT] ||
      ((!respect || ctrl_q[c][margin_ctrl_pkg::RUN_BIT]) &&
      (!src_q[c][margin_ctrl_pkg::SRC_PIN_BIT] || pin_on));
    target_slew u_slew (.clk_in(clk_in), .rst_n_in(rst_n_in), .goal_in(goal[c]), .rate_in(slew_q[c]),
      .level_out(level[c]));
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  wire [7:0] comms_set = {bad_cmd, bad_data, 6'h00};
  wire comms_clr = wr_ok && h_code_q == margin_ctrl_pkg::CODE_COMMS;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ack_q <= 1'b0;
      rdata_core_q <= 16'h0000;
      page_q <= margin_ctrl_pkg::PAGE_A;
      phase_q <= margin_ctrl_pkg::PHASE_TOTAL;
      comms_q <= 8'h00;
      run_q <= 2'b00;
    end else begin
      run_q <= on_d;
      if (txn_new) begin
        ack_q <= req_core;
        rdata_core_q <= txn_good ? rd_mux : 16'h0000;
      end
      if (wr_ok && h_code_q == margin_ctrl_pkg::CODE_PAGE) page_q <= h_data_q[7:0];
      if (wr_ok && h_code_q == margin_ctrl_pkg::CODE_PHASE) phase_q <= h_data_q[7:0];
      // a fresh fault wins over a clear in the same cycle
      comms_q <= (comms_clr ? comms_q & ~h_data_q[7:0] : comms_q) | comms_set;
    end
  end

  always_ff @(posedge clk_in) begin
    for (int c = 0; c < 2; c++) begin
      if (!rst_n_in) begin
        ctrl_q[c] <= margin_ctrl_pkg::CONTROL_RESET;
        src_q[c] <= margin_ctrl_pkg::ENABLE_SRC_RESET;
        nom_q[c] <= NOMINAL_RESET;
        ceil_q[c] <= CEILING_RESET;
        low_q[c] <= 8'h00;
        high_q[c] <= 8'h00;
        slew_q[c] <= 8'h00;
        vflags_q[c] <= 8'h00;
        ofs_q[c] <= margin_ctrl_pkg::OFS_RESET;
      end else begin
        if (wr_ok && sel_mask[c]) begin
          unique case (h_code_q)
            margin_ctrl_pkg::CODE_CONTROL: ctrl_q[c] <= h_data_q[7:0] & margin_ctrl_pkg::CONTROL_WMASK;
            margin_ctrl_pkg::CODE_ENABLE_SRC: src_q[c] <= h_data_q[7:0];
            margin_ctrl_pkg::CODE_NOMINAL: nom_q[c] <= h_data_q[7:0];
            margin_ctrl_pkg::CODE_CEILING: ceil_q[c] <= h_data_q[7:0];
            margin_ctrl_pkg::CODE_LOW_TRIM: low_q[c] <= h_data_q[7:0];
            margin_ctrl_pkg::CODE_HIGH_TRIM: high_q[c] <= h_data_q[7:0];
            margin_ctrl_pkg::CODE_SLEW: slew_q[c] <= h_data_q[7:0];
            margin_ctrl_pkg::CODE_OFFSET: ofs_q[c] <= h_data_q;
            default: ;
          endcase
        end
        vflags_q[c] <= ((wr_ok && sel_mask[c] && h_code_q == margin_ctrl_pkg::CODE_VFLAGS) ?
          vflags_q[c] & ~h_data_q[7:0] : vflags_q[c]) |
          {4'h0, warn_set[c], 3'b000};
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign host_alert_line_out = 1'b0;
  assign host_alert_line_oe_out = |comms_q;
  assign run_out = run_q;
  assign target_a_out = level[0];
  assign target_b_out = level[1];
  assign fault_detect_en_out = fault_en;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_trim_reject: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_ok == 1'b0 && txn_new && h_code_q == margin_ctrl_pkg::CODE_CONTROL && h_write_q
    |=> ctrl_q[0] == $past(ctrl_q[0]) && ctrl_q[1] == $past(ctrl_q[1]) && host_alert_line_oe_out)
    else $error("rejected control write changed state or left alert off");
  a_bad_offset: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    txn_new && h_write_q && h_code_q == margin_ctrl_pkg::CODE_OFFSET &&
    phase_q == margin_ctrl_pkg::PHASE_TOTAL && h_data_q[0] |=> comms_q[margin_ctrl_pkg::COMMS_BAD_DATA])
    else $error("odd total offset word accepted");
  a_both_pages: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_ctrl && page_q == margin_ctrl_pkg::PAGE_BOTH |=> ctrl_q[0] == ctrl_q[1])
    else $error("both-page write left channels different");
  a_nom_ceiling: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    nom_q[0] <= ceil_q[0] && nom_q[1] <= ceil_q[1])
    else $error("nominal target above ceiling");
  a_ignore_faults: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    src_q[0][margin_ctrl_pkg::SRC_CMD_BIT] && ctrl_q[0][3:2] == margin_ctrl_pkg::FAULT_IGNORE &&
    ctrl_q[0][5:4] != 2'b00 |-> !fault_detect_en_out[0])
    else $error("faults still enabled in ignore trim");
  a_run_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    src_q[0] == margin_ctrl_pkg::ENABLE_SRC_RESET && $stable(src_q[0]) && pin_s[0] ##1
    $stable(ctrl_q[0]) |-> run_out[0] == $past(ctrl_q[0][margin_ctrl_pkg::RUN_BIT]))
    else $error("run output does not follow run bit");
  a_high_goal: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    src_q[0][margin_ctrl_pkg::SRC_CMD_BIT] && ctrl_q[0][5:4] == margin_ctrl_pkg::SEL_HIGH
    |-> goal[0] == high_q[0])
    else $error("high trim not selected");
  a_warn_raise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    warn_set[0] |=> vflags_q[0][margin_ctrl_pkg::VFLAG_CEILING_WARN] && summary[margin_ctrl_pkg::SUMMARY_VOUT] | rd_ch)
    else $error("ceiling warning not raised");
endmodule
`default_nettype wire

// ==== rtl/margin_ctrl_pkg.sv ====
`default_nettype none
package margin_ctrl_pkg;
  // command codes of the host transaction port
  localparam logic [7:0] CODE_PAGE = 8'h00;
  localparam logic [7:0] CODE_CONTROL = 8'h01;
  localparam logic [7:0] CODE_ENABLE_SRC = 8'h02;
  localparam logic [7:0] CODE_PHASE = 8'h04;
  localparam logic [7:0] CODE_NOMINAL = 8'h21;
  localparam logic [7:0] CODE_CEILING = 8'h24;
  localparam logic [7:0] CODE_HIGH_TRIM = 8'h25;
  localparam logic [7:0] CODE_LOW_TRIM = 8'h26;
  localparam logic [7:0] CODE_SLEW = 8'h27;
  localparam logic [7:0] CODE_OFFSET = 8'h39;
  localparam logic [7:0] CODE_SUMMARY = 8'h78;
  localparam logic [7:0] CODE_VFLAGS = 8'h7a;
  localparam logic [7:0] CODE_COMMS = 8'h7e;
  // page and phase pointer values
  localparam logic [7:0] PAGE_A = 8'h00;
  localparam logic [7:0] PAGE_B = 8'h01;
  localparam logic [7:0] PAGE_BOTH = 8'hff;
  localparam logic [7:0] PHASE_TOTAL = 8'h80;
  // control command fields
  localparam int RUN_BIT = 7;
  localparam int TRIM_HI = 5;
  localparam int TRIM_LO = 2;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'hbf;
  localparam logic [3:0] TRIM_OFF = 4'h0;
  localparam logic [3:0] TRIM_LOW_IGN = 4'h5;
  localparam logic [3:0] TRIM_LOW_ACT = 4'h6;
  localparam logic [3:0] TRIM_HIGH_IGN = 4'h9;
  localparam logic [3:0] TRIM_HIGH_ACT = 4'ha;
  localparam logic [1:0] SEL_LOW = 2'h1;
  localparam logic [1:0] SEL_HIGH = 2'h2;
  localparam logic [1:0] FAULT_IGNORE = 2'h1;
  localparam logic [1:0] FAULT_ACT = 2'h2;
  // enable source fields
  localparam int SRC_PU_BIT = 4;
  localparam int SRC_CMD_BIT = 3;
  localparam int SRC_PIN_BIT = 2;
  localparam int SRC_POL_BIT = 1;
  localparam logic [7:0] ENABLE_SRC_RESET = 8'h1e;
  // total-current offset words, 0.25 A per even step
  localparam logic [15:0] OFS_POS_MIN = 16'he800;
  localparam logic [15:0] OFS_POS_MAX = 16'he820;
  localparam logic [15:0] OFS_NEG_MIN = 16'hefe2;
  localparam logic [15:0] OFS_NEG_MAX = 16'heffe;
  // individual-phase offset words, 0.125 A per step
  localparam logic [15:0] OFS_PH_POS_MAX = 16'he808;
  localparam logic [15:0] OFS_PH_NEG_MIN = 16'heff9;
  localparam logic [15:0] OFS_PH_NEG_MAX = 16'hefff;
  localparam logic [15:0] OFS_RESET = 16'he800;
  // status bits
  localparam int COMMS_BAD_CMD = 7;
  localparam int COMMS_BAD_DATA = 6;
  localparam int SUMMARY_VOUT = 5;
  localparam int SUMMARY_COMMS = 1;
  localparam int VFLAG_CEILING_WARN = 3;
  // slew: one target step per (rate+1) units of this time
  localparam int SLEW_UNIT_NS = 1000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SLEW_UNIT_CYC = (SLEW_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ==== rtl/bit_sync2.sv ====
`default_nettype none
module bit_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  if (WIDTH < 1) $error("synchroniser width must be at least one");

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// ==== rtl/target_slew.sv ====
`default_nettype none
module target_slew (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] goal_in,
  input wire logic [7:0] rate_in,
  output logic [7:0] level_out
);
  logic [7:0] level_q;
  logic [15:0] cnt_q;
  wire [15:0] limit = 16'((rate_in + 9'h001) * margin_ctrl_pkg::SLEW_UNIT_CYC - 1);
  wire moving = level_q != goal_in;
  wire tick = moving && cnt_q >= limit;

  // one vid step per tick, never a jump
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      level_q <= 8'h00;
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= (!moving || tick) ? 16'h0000 : cnt_q + 16'h0001;
      if (tick) level_q <= (goal_in > level_q) ? level_q + 8'h01 : level_q - 8'h01;
    end
  end

  assign level_out = level_q;

  a_slew_one_step: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    level_q != $past(level_q) |-> (level_q - $past(level_q) == 8'h01 || $past(level_q) - level_q == 8'h01))
    else $error("target moved by more than one step");
endmodule
`default_nettype wire

// ==== test/host_model.sv ====
`default_nettype none
module host_model (
  input wire logic link_clk_in,
  input wire logic txn_ready_in,
  input wire logic rd_valid_in,
  input wire logic [15:0] rd_data_in,
  output logic txn_valid_out = 1'b0,
  output logic txn_write_out = 1'b0,
  output logic txn_word_out = 1'b0,
  output logic [7:0] txn_code_out = 8'h00,
  output logic [15:0] txn_data_out = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  bit hung = 1'b0;
  logic [15:0] last_rd = 16'h0000;
  // one request outstanding, held up to the edge that samples ready
  task automatic xfer(input logic wr, input logic wd, input logic [7:0] c, input logic [15:0] d);
    int n;
    bit got;
    n = 0;
    got = 1'b0;
    @(posedge link_clk_in);
    while (txn_ready_in !== 1'b1 && n < 200) begin
      @(posedge link_clk_in);
      n++;
    end
    txn_valid_out <= 1'b1;
    txn_write_out <= wr;
    txn_word_out <= wd;
    txn_code_out <= c;
    txn_data_out <= d;
    @(posedge link_clk_in);
    // released code and data lines carry garbage so stale data is never reused
    txn_valid_out <= 1'b0;
    txn_code_out <= ~c;
    txn_data_out <= ~d;
    do begin
      @(posedge link_clk_in);
      n++;
      if (rd_valid_in === 1'b1) begin
        last_rd = rd_data_in;
        got = 1'b1;
      end
    end while ((txn_ready_in !== 1'b1 || !(wr || got)) && n < 200);
    if (n >= 200) hung = 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== test/output_margin_control_tb.sv ====
`default_nettype none
module output_margin_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, lclk = 1'b0, rst_n = 1'b0, lrst_n = 1'b0, pin_a = 1'b1, pin_b = 1'b0;
  logic v, w, wd, rdv, rdy, al, al_oe;
  logic [7:0] c, ta, tb;
  logic [15:0] d, rq;
  logic [1:0] run, fen;
  int mismatches = 0, check_count = 0;
  logic [15:0] ofs [6] = '{16'he802, 16'he801, 16'he822, 16'hefe0, 16'heffe, 16'he820};
  logic [15:0] ex = 16'he800;
  wire alert_n = al_oe ? al : 1'b1;
  always #25 clk_in = ~clk_in;
  initial begin
    #1.7;
    forever #3 lclk = ~lclk;
  end
  output_margin_control output_margin_control_inst (.clk_in(clk_in), .rst_n_in(rst_n), .link_clk_in(lclk),
    .link_rst_n_in(lrst_n), .txn_valid_in(v), .txn_write_in(w), .txn_word_in(wd), .txn_code_in(c),
    .txn_data_in(d), .txn_ready_out(rdy), .rd_valid_out(rdv), .rd_data_out(rq),
    .channel_a_enable_pin_in(pin_a), .channel_b_enable_pin_in(pin_b), .host_alert_line_out(al),
    .host_alert_line_oe_out(al_oe), .run_out(run), .target_a_out(ta), .target_b_out(tb),
    .fault_detect_en_out(fen));
  host_model host_model_inst (.link_clk_in(lclk), .txn_ready_in(rdy), .rd_valid_in(rdv), .rd_data_in(rq),
    .txn_valid_out(v), .txn_write_out(w), .txn_word_out(wd), .txn_code_out(c), .txn_data_out(d));
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hang;
    if (host_model_inst.hung) begin
      mismatches++;
      final_report;
    end
  endtask
  task automatic wr(input logic [7:0] cd, input logic [15:0] dt);
    host_model_inst.xfer(1'b1, cd inside {8'h21, 8'h24, 8'h25, 8'h26, 8'h27, 8'h39}, cd, dt);
    hang;
  endtask
  task automatic rd(input logic [7:0] cd, input logic [15:0] e, input logic [15:0] m = 16'hffff);
    host_model_inst.xfer(1'b0, cd inside {8'h21, 8'h24, 8'h25, 8'h26, 8'h27, 8'h39}, cd, 16'h0000);
    hang;
    chk(host_model_inst.last_rd & m, e);
  endtask
  task automatic wait_tgt(input logic [7:0] e, input bit chb = 1'b0);
    int n;
    n = 0;
    while ((chb ? tb : ta) !== e && n < 1000) begin
      @(posedge clk_in);
      n++;
    end
    chk(16'(chb ? tb : ta), 16'(e));
    if (n >= 1000) final_report;
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    rst_n <= 1'b1;
    @(posedge lclk);
    lrst_n <= 1'b1;
    rd(8'h01, 16'h0000);
    wr(8'h00, 16'h0000);
    wr(8'h21, 16'h0010);
    wr(8'h26, 16'h0008);
    wr(8'h25, 16'h0020);
    wait_tgt(8'h10);
    wr(8'h27, 16'h0001);
    wr(8'h01, 16'h0094);
    chk(16'(ta > 8'h0e), 16'h0001);
    repeat (60) @(posedge clk_in);
    chk(16'(ta), 16'h000f);
    wr(8'h27, 16'h0000);
    wait_tgt(8'h08);
    chk(16'(fen[0]), 16'h0000);
    chk(16'(run), 16'h0001);
    wr(8'h01, 16'h00a8);
    wait_tgt(8'h20);
    chk(16'(fen[0]), 16'h0001);
    rd(8'h7a, 16'h0008, 16'h0008);
    pin_a <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk(16'(run), 16'h0000);
    pin_a <= 1'b1;
    wr(8'h02, 16'h0016);
    wait_tgt(8'h10);
    wr(8'h02, 16'h001e);
    $display("trim test done");
    wr(8'h00, 16'h0001);
    rd(8'h01, 16'h0000);
    wr(8'h00, 16'h00ff);
    wr(8'h01, 16'h0083);
    rd(8'h01, 16'h0083);
    wr(8'h21, 16'h0010);
    wait_tgt(8'h10, 1'b1);
    wr(8'h00, 16'h0001);
    rd(8'h01, 16'h0083);
    $display("page test done");
    wr(8'h00, 16'h0000);
    wr(8'h01, 16'h009c);
    rd(8'h01, 16'h0083);
    rd(8'h7e, 16'h0040, 16'h0040);
    rd(8'h78, 16'h0002, 16'h0002);
    chk(16'(alert_n), 16'h0000);
    wr(8'h7e, 16'h00c0);
    repeat (4) @(posedge clk_in);
    chk(16'(alert_n), 16'h0001);
    host_model_inst.xfer(1'b1, 1'b1, 8'h01, 16'h0080);
    rd(8'h01, 16'h0083);
    wr(8'h55, 16'h0000);
    rd(8'h7e, 16'h00c0);
    $display("reject test done");
    for (int i = 0; i < 6; i++) begin
      wr(8'h39, ofs[i]);
      if (i inside {0, 4, 5}) ex = ofs[i];
      rd(8'h39, ex);
    end
    wr(8'h04, 16'h0000);
    wr(8'h39, 16'he801);
    rd(8'h39, 16'he801);
    wr(8'h24, 16'h0030);
    wr(8'h21, 16'h0040);
    rd(8'h21, 16'h0010);
    $display("limit test done");
    final_report;
  end
endmodule
`default_nettype wire
